// >>> bridge_cfg_pkg.sv
/*
 * Shared constants for the bridge configuration block: register indices,
 * field positions, reset values, timing counts and the DDC slave states.
 * Assumes a single 250 MHz register clock.
 */
package bridge_cfg_pkg;
	localparam int unsigned CLK_NS = 4;
	localparam int unsigned APB_AW = 12;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_BRIDGE_STATUS = 10'h050;
	localparam logic [9:0] IDX_SLAVE_ADDR = 10'h051;
	localparam logic [9:0] IDX_TIMING0    = 10'h052;
	localparam logic [9:0] IDX_TIMING1    = 10'h053;
	localparam logic [9:0] IDX_BRIDGE_CFG = 10'h054;
	localparam logic [9:0] IDX_IRQ_STS    = 10'h056;
	localparam logic [9:0] IDX_IRQ_MASK   = 10'h057;

	// Reset values
	localparam logic [6:0] SLAVE_ID_RST = 7'h50;
	localparam logic       WPROT_RST    = 1'b0;
	localparam logic [2:0] HOLD_RST     = 3'h1;
	localparam logic [3:0] FILT_RST     = 4'he;
	localparam logic [1:0] DLY_RST      = 2'h0;
	localparam logic [7:0] BRIDGE_RST   = 8'h00;
	localparam logic [2:0] MASK_RST     = 3'h0;

	// Field positions
	localparam int unsigned HOLD_LSB    = 4;
	localparam int unsigned BIT_EXT     = 7;
	localparam int unsigned BIT_INT_EN  = 6;
	localparam int unsigned BIT_REM_DIS = 5;
	localparam int unsigned BIT_INI_DIS = 4;
	localparam int unsigned BIT_PRT_DIS = 3;
	localparam int unsigned BIT_TDM     = 2;
	localparam int unsigned BIT_LOCAL   = 1;
	localparam int unsigned BIT_AUX     = 0;
	localparam int unsigned STS_RX      = 6;
	localparam int unsigned STS_PRT     = 5;
	localparam int unsigned IRQ_RX      = 0;
	localparam int unsigned IRQ_PRT     = 1;
	localparam int unsigned IRQ_WREJ    = 2;

	// Timing steps in ns and derived cycle counts
	localparam int unsigned HOLD_STEP_NS = 40;
	localparam int unsigned FILT_STEP_NS = 5;
	localparam int unsigned DLY_BASE_NS  = 240;
	localparam int unsigned DLY_STEP_NS  = 40;
	localparam int unsigned HOLD_STEP_CYC = (HOLD_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned DLY_BASE_CYC  = (DLY_BASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned DLY_STEP_CYC  = (DLY_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0]  STRAP_LOAD_CNT = 2'h2;

	typedef enum logic [6:0] {
		S_IDLE  = 7'b0000001,
		S_ADDR  = 7'b0000010,
		S_AACK  = 7'b0000100,
		S_WDATA = 7'b0001000,
		S_WACK  = 7'b0010000,
		S_RDATA = 7'b0100000,
		S_RACK  = 7'b1000000
	} ddc_state_t;
endpackage

// >>> line_sync.sv
/*
 * Two-flop synchroniser for a pin.
 * Assumes the pin is asynchronous to clk; only the second stage is read.
 */
`timescale 1ns/1ns
`default_nettype none
module line_sync #(
	parameter bit RST_VAL = 1'b1
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Pin and synchronised level
	input  wire logic din,
	output var  logic dout_q
);
	logic meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			dout_q <= RST_VAL;
		end else begin
			meta_q <= din;
			dout_q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// >>> glitch_filter.sv
/*
 * Glitch filter: output follows input only after it has differed
 * for thr+1 cycles. Assumes din is already synchronised.
 */
`timescale 1ns/1ns
`default_nettype none
module glitch_filter (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Line and threshold in cycles
	input  wire logic       din,
	input  wire logic [4:0] thr,
	output var  logic       dout_q
);
	logic [4:0] cnt_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= 5'h00;
			dout_q <= 1'b1;
		end else if (din == dout_q) begin
			cnt_q <= 5'h00;
		end else if (cnt_q >= thr) begin
			dout_q <= din;
			cnt_q  <= 5'h00;
		end else begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	a_glitch_reject: assert property (@(posedge clk) disable iff (!rst_n)
		(din != dout_q && cnt_q == 5'h00 && thr != 5'h00) |=> dout_q == $past(dout_q))
		else $error("glitch filter passed a short pulse");
endmodule
`default_nettype wire

// >>> bridge_ddc_display_config.sv
/*
 * Bridge configuration register bank with its display-identification
 * DDC slave front end, strap capture and interrupt reporting.
 * Assumes an APB master on pclk, an identification memory that presents
 * the next read byte on id_rd_data and accepts id_wr_valid pulses, and
 * DDC pins driven open-drain by an external pad.
 */
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module bridge_ddc_display_config (
	// Clock and reset
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	// APB slave
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [bridge_cfg_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                       pwdata,
	input  wire logic [3:0]                        pstrb,
	output var  logic [31:0]                       prdata,
	output var  logic                              pready,
	output var  logic                              pslverr,
	// DDC pins
	input  wire logic                              display_channel_clock,
	input  wire logic                              display_channel_data_in,
	output var  logic                              display_channel_data_out,
	output var  logic                              display_channel_data_oe_n,
	// Identification memory port
	input  wire logic [7:0]                        id_rd_data,
	output var  logic                              id_rd_next,
	output var  logic                              id_xfer_start,
	output var  logic                              id_xfer_read,
	output var  logic                              id_wr_valid,
	output var  logic [7:0]                        id_wr_data,
	// Straps
	input  wire logic                              strap_pin_a,
	input  wire logic                              strap_pin_b,
	// Interrupt sources and pin
	input  wire logic                              rx_irq_pending,
	input  wire logic                              protection_tx_irq_pending,
	output var  logic                              interrupt_out_n,
	// Bridge control
	output var  logic                              external_control_select,
	output var  logic                              receiver_auto_init_en,
	output var  logic                              protection_auto_setup_en,
	output var  logic                              remote_id_load_en,
	output var  logic                              audio_tdm_en,
	output var  logic                              audio_local_sel,
	output var  logic                              aux_audio_en
);
	import bridge_cfg_pkg::*;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [6:0]  slave_id_q;
	logic        wprot_q;
	logic [2:0]  hold_q;
	logic [3:0]  filt_q;
	logic [1:0]  dly_q;
	logic [7:0]  bridge_q;
	logic [2:0]  irq_sts_q;
	logic [2:0]  irq_mask_q;
	logic [2:0]  irq_evt;
	logic        irq_q;
	logic        rx_prev_q;
	logic        prt_prev_q;
	logic [1:0]  strap_cnt_q;
	logic        strap_done_q;
	logic        strap_a_s;
	logic        strap_b_s;
	logic        scl_s;
	logic        sda_s;
	logic        scl_f;
	logic        sda_f;
	logic        scl_prev_q;
	logic        sda_prev_q;
	logic [4:0]  filt_thr;
	logic [6:0]  hold_thr;
	logic [6:0]  dly_thr;
	logic        scl_rise;
	logic        scl_fall;
	logic        cond_pend_q;
	logic        cond_stop_q;
	logic [6:0]  hold_cnt_q;
	logic        cond_ok;
	logic        start_det;
	logic        stop_det;
	ddc_state_t  state_q;
	logic [3:0]  bit_cnt_q;
	logic [7:0]  shift_q;
	logic        mack_q;
	logic        drive_tgt_q;
	logic        sda_drive_q;
	logic [6:0]  dly_cnt_q;
	logic        wr_reject_q;
	logic        addr_hit;
	logic [9:0]  idx;
	logic        aligned;
	logic        mapped;
	logic        setup_ph;
	logic        wr_acc;
	logic [31:0] rdata;

	// Pins cross into pclk before anything looks at them
	line_sync #(.RST_VAL(1'b1)) u_sync_scl (.clk(pclk), .rst_n(presetn), .din(display_channel_clock),
		.dout_q(scl_s));
	line_sync #(.RST_VAL(1'b1)) u_sync_sda (.clk(pclk), .rst_n(presetn), .din(display_channel_data_in),
		.dout_q(sda_s));
	line_sync #(.RST_VAL(1'b0)) u_sync_sta (.clk(pclk), .rst_n(presetn), .din(strap_pin_a),
		.dout_q(strap_a_s));
	line_sync #(.RST_VAL(1'b0)) u_sync_stb (.clk(pclk), .rst_n(presetn), .din(strap_pin_b),
		.dout_q(strap_b_s));

	// Depth in 5 ns units, rounded up to whole cycles
	assign filt_thr = 5'((7'(filt_q) * 7'(FILT_STEP_NS) + 7'(CLK_NS - 1)) / 7'(CLK_NS));
	assign hold_thr = 7'(hold_q) * 7'(HOLD_STEP_CYC);
	assign dly_thr  = 7'(DLY_BASE_CYC) + 7'(dly_q) * 7'(DLY_STEP_CYC);

	glitch_filter u_filt_scl (.clk(pclk), .rst_n(presetn), .din(scl_s), .thr(filt_thr), .dout_q(scl_f));
	glitch_filter u_filt_sda (.clk(pclk), .rst_n(presetn), .din(sda_s), .thr(filt_thr), .dout_q(sda_f));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_f;
			sda_prev_q <= sda_f;
		end
	end

	assign scl_rise = scl_f & ~scl_prev_q;
	assign scl_fall = ~scl_f & scl_prev_q;

	// Start/stop is taken only once data has held its new level with clock high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_pend_q <= 1'b0;
			cond_stop_q <= 1'b0;
			hold_cnt_q  <= 7'h00;
		end else if (scl_f && scl_prev_q && sda_f != sda_prev_q) begin
			cond_pend_q <= 1'b1;
			cond_stop_q <= sda_f;
			hold_cnt_q  <= 7'h00;
		end else if (cond_pend_q) begin
			if (!scl_f || sda_f != cond_stop_q || hold_cnt_q >= hold_thr) begin
				cond_pend_q <= 1'b0;
			end else begin
				hold_cnt_q <= hold_cnt_q + 7'h01;
			end
		end
	end

	assign cond_ok   = cond_pend_q & scl_f & (sda_f == cond_stop_q) & (hold_cnt_q >= hold_thr);
	assign start_det = cond_ok & ~cond_stop_q;
	assign stop_det  = cond_ok & cond_stop_q;
	assign addr_hit  = shift_q[7:1] == slave_id_q;

	// DDC slave sequencing; data changes are decided on clock fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q       <= S_IDLE;
			bit_cnt_q     <= 4'h0;
			shift_q       <= 8'h00;
			mack_q        <= 1'b0;
			drive_tgt_q   <= 1'b0;
			id_xfer_read  <= 1'b0;
			id_wr_data    <= 8'h00;
			id_xfer_start <= 1'b0;
			id_wr_valid   <= 1'b0;
			id_rd_next    <= 1'b0;
			wr_reject_q   <= 1'b0;
		end else begin
			id_xfer_start <= 1'b0;
			id_wr_valid   <= 1'b0;
			id_rd_next    <= 1'b0;
			wr_reject_q   <= 1'b0;
			if (start_det) begin
				state_q     <= S_ADDR;
				bit_cnt_q   <= 4'h0;
				drive_tgt_q <= 1'b0;
			end else if (stop_det) begin
				state_q     <= S_IDLE;
				drive_tgt_q <= 1'b0;
			end else if (scl_rise) begin
				if (state_q == S_ADDR || state_q == S_WDATA) begin
					shift_q   <= {shift_q[6:0], sda_f};
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end
				if (state_q == S_RACK) begin
					mack_q <= ~sda_f;
				end
			end else if (scl_fall) begin
				unique case (state_q)
					S_IDLE: begin
						drive_tgt_q <= 1'b0;
					end
					S_ADDR: begin
						if (bit_cnt_q == 4'h8) begin
							if (addr_hit && (shift_q[0] || !wprot_q)) begin
								state_q       <= S_AACK;
								drive_tgt_q   <= 1'b1;
								id_xfer_read  <= shift_q[0];
								id_xfer_start <= 1'b1;
							end else begin
								state_q     <= S_IDLE;
								wr_reject_q <= addr_hit;
							end
						end
					end
					S_WDATA: begin
						if (bit_cnt_q == 4'h8) begin
							state_q     <= S_WACK;
							drive_tgt_q <= 1'b1;
							id_wr_valid <= 1'b1;
							id_wr_data  <= shift_q;
						end
					end
					S_RDATA: begin
						if (bit_cnt_q == 4'h8) begin
							state_q     <= S_RACK;
							drive_tgt_q <= 1'b0;
						end else begin
							drive_tgt_q <= ~shift_q[7];
							shift_q     <= {shift_q[6:0], 1'b0};
							bit_cnt_q   <= bit_cnt_q + 4'h1;
						end
					end
					S_WACK: begin
						state_q     <= S_WDATA;
						bit_cnt_q   <= 4'h0;
						drive_tgt_q <= 1'b0;
					end
					S_AACK, S_RACK: begin
						if ((state_q == S_AACK && id_xfer_read) || (state_q == S_RACK && mack_q)) begin
							state_q     <= S_RDATA;
							shift_q     <= {id_rd_data[6:0], 1'b0};
							drive_tgt_q <= ~id_rd_data[7];
							bit_cnt_q   <= 4'h1;
							id_rd_next  <= 1'b1;
						end else begin
							state_q     <= (state_q == S_AACK) ? S_WDATA : S_IDLE;
							bit_cnt_q   <= 4'h0;
							drive_tgt_q <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	// Output delay counts from the filtered clock fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_cnt_q   <= 7'h00;
			sda_drive_q <= 1'b0;
		end else if (start_det || stop_det) begin
			dly_cnt_q   <= 7'h00;
			sda_drive_q <= 1'b0;
		end else if (scl_fall) begin
			dly_cnt_q <= dly_thr;
		end else if (dly_cnt_q != 7'h00) begin
			dly_cnt_q <= dly_cnt_q - 7'h01;
			if (dly_cnt_q == 7'h01) begin
				sda_drive_q <= drive_tgt_q;
			end
		end
	end

	assign display_channel_data_out  = 1'b0;
	assign display_channel_data_oe_n = ~sda_drive_q;

	// APB decode; registers sit at four times their index
	assign idx      = paddr[11:2];
	assign aligned  = paddr[1:0] == 2'h0;
	assign mapped   = aligned && (idx == IDX_BRIDGE_STATUS || idx == IDX_SLAVE_ADDR || idx == IDX_TIMING0 ||
		idx == IDX_TIMING1 || idx == IDX_BRIDGE_CFG || idx == IDX_IRQ_STS || idx == IDX_IRQ_MASK);
	assign setup_ph = psel & ~penable;
	assign wr_acc   = psel & penable & pwrite & pstrb[0] & mapped;
	assign pready   = psel & penable;
	assign pslverr  = psel & penable & ~mapped;

	always_comb begin
		rdata = 32'h0000_0000;
		if (aligned) begin
			unique case (idx)
				IDX_BRIDGE_STATUS: begin
					rdata[STS_RX]  = rx_irq_pending;
					rdata[STS_PRT] = protection_tx_irq_pending;
				end
				IDX_SLAVE_ADDR: rdata[7:0] = {slave_id_q, wprot_q};
				IDX_TIMING0:    rdata[7:0] = {1'b0, hold_q, filt_q};
				IDX_TIMING1:    rdata[7:0] = {6'h00, dly_q};
				IDX_BRIDGE_CFG: rdata[7:0] = bridge_q;
				IDX_IRQ_STS:    rdata[2:0] = irq_sts_q;
				IDX_IRQ_MASK:   rdata[2:0] = irq_mask_q;
				default:        rdata = 32'h0000_0000;
			endcase
		end
	end

	// Read data is captured in setup so it comes from a flop in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_ph) begin
			prdata <= pwrite ? 32'h0000_0000 : rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slave_id_q <= SLAVE_ID_RST;
			wprot_q    <= WPROT_RST;
			hold_q     <= HOLD_RST;
			filt_q     <= FILT_RST;
			dly_q      <= DLY_RST;
			irq_mask_q <= MASK_RST;
		end else if (wr_acc) begin
			unique case (idx)
				IDX_SLAVE_ADDR: {slave_id_q, wprot_q} <= pwdata[7:0];
				IDX_TIMING0:    {hold_q, filt_q} <= pwdata[6:0];
				IDX_TIMING1:    dly_q <= pwdata[1:0];
				IDX_IRQ_MASK:   irq_mask_q <= pwdata[2:0];
				default:        irq_mask_q <= irq_mask_q;
			endcase
		end
	end

	// Straps are caught once the synchronisers hold the pin levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_cnt_q  <= 2'h0;
			strap_done_q <= 1'b0;
			bridge_q     <= BRIDGE_RST;
		end else if (!strap_done_q) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == STRAP_LOAD_CNT) begin
				strap_done_q         <= 1'b1;
				bridge_q[BIT_EXT]     <= strap_b_s;
				bridge_q[BIT_REM_DIS] <= strap_b_s;
				bridge_q[BIT_AUX]     <= strap_a_s;
			end
		end else if (wr_acc && idx == IDX_BRIDGE_CFG) begin
			bridge_q <= pwdata[7:0];
		end
	end

	// Bridge control enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			external_control_select  <= 1'b0;
			receiver_auto_init_en    <= 1'b0;
			protection_auto_setup_en <= 1'b0;
			remote_id_load_en        <= 1'b0;
			audio_tdm_en             <= 1'b0;
			audio_local_sel          <= 1'b0;
			aux_audio_en             <= 1'b0;
		end else begin
			external_control_select  <= bridge_q[BIT_EXT];
			receiver_auto_init_en    <= strap_done_q & ~bridge_q[BIT_EXT] & ~bridge_q[BIT_INI_DIS];
			protection_auto_setup_en <= strap_done_q & ~bridge_q[BIT_EXT] & ~bridge_q[BIT_PRT_DIS];
			remote_id_load_en        <= strap_done_q & ~bridge_q[BIT_REM_DIS];
			audio_tdm_en             <= bridge_q[BIT_TDM];
			audio_local_sel          <= bridge_q[BIT_LOCAL];
			aux_audio_en             <= bridge_q[BIT_AUX];
		end
	end

	// Sticky events; a read clears only what it returned, so set wins
	assign irq_evt[IRQ_RX]   = rx_irq_pending & ~rx_prev_q;
	assign irq_evt[IRQ_PRT]  = protection_tx_irq_pending & ~prt_prev_q;
	assign irq_evt[IRQ_WREJ] = wr_reject_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_prev_q  <= 1'b0;
			prt_prev_q <= 1'b0;
			irq_sts_q  <= 3'h0;
			irq_q      <= 1'b0;
		end else begin
			rx_prev_q  <= rx_irq_pending;
			prt_prev_q <= protection_tx_irq_pending;
			if (pready && !pwrite && aligned && idx == IDX_IRQ_STS) begin
				irq_sts_q <= (irq_sts_q & ~prdata[2:0]) | irq_evt;
			end else begin
				irq_sts_q <= irq_sts_q | irq_evt;
			end
			irq_q <= |(irq_sts_q & irq_mask_q & {2'b11, bridge_q[BIT_INT_EN]});
		end
	end

	assign interrupt_out_n = ~irq_q;

	a_addr_mismatch: assert property (
		scl_fall && !cond_ok && state_q == S_ADDR && bit_cnt_q == 4'h8 && !addr_hit |=> state_q == S_IDLE)
		else $error("slave acknowledged a foreign address");
	a_write_protect: assert property (
		scl_fall && !cond_ok && state_q == S_ADDR && bit_cnt_q == 4'h8 && addr_hit && !shift_q[0] && wprot_q
		|=> state_q == S_IDLE && wr_reject_q && !id_xfer_start)
		else $error("protected write was accepted");
	a_hold_qualify: assert property (
		cond_pend_q && hold_cnt_q < hold_thr |-> !start_det && !stop_det)
		else $error("start or stop taken before hold time");
	a_output_delay: assert property (
		scl_fall && !cond_ok |=> $stable(sda_drive_q)[*8])
		else $error("data output changed too soon after clock fall");
	a_delay_apply: assert property (
		dly_cnt_q == 7'h01 && !scl_fall && !cond_ok |=> sda_drive_q == $past(drive_tgt_q))
		else $error("delayed data not applied");
	a_ext_control: assert property (
		bridge_q[BIT_EXT] |=> !receiver_auto_init_en && !protection_auto_setup_en)
		else $error("bridge control active under external control");
	a_rx_irq_gate: assert property (
		!bridge_q[BIT_INT_EN] && (irq_sts_q & irq_mask_q & 3'b110) == 3'h0 |=> interrupt_out_n)
		else $error("receiver interrupt reported while disabled");
	a_rx_irq_pin: assert property (
		bridge_q[BIT_INT_EN] && irq_sts_q[IRQ_RX] && irq_mask_q[IRQ_RX] |=> !interrupt_out_n)
		else $error("enabled receiver interrupt not reported");
	a_remote_load: assert property (
		bridge_q[BIT_REM_DIS] |=> !remote_id_load_en)
		else $error("remote load enabled while disabled");
	a_auto_init: assert property (
		bridge_q[BIT_INI_DIS] |=> !receiver_auto_init_en)
		else $error("receiver init enabled while disabled");
	a_auto_protect: assert property (
		bridge_q[BIT_PRT_DIS] |=> !protection_auto_setup_en)
		else $error("protection setup enabled while disabled");
	a_audio_tdm: assert property (
		##1 audio_tdm_en == $past(bridge_q[BIT_TDM]))
		else $error("tdm audio select mismatch");
	a_audio_source: assert property (
		##1 audio_local_sel == $past(bridge_q[BIT_LOCAL]))
		else $error("audio source select mismatch");
	a_aux_strap: assert property (
		!strap_done_q && strap_cnt_q == STRAP_LOAD_CNT
		|=> bridge_q[BIT_AUX] == $past(strap_a_s) ##1 aux_audio_en == $past(bridge_q[BIT_AUX]))
		else $error("auxiliary audio strap not loaded");
	a_pending_flags: assert property (
		setup_ph && !pwrite && aligned && idx == IDX_BRIDGE_STATUS
		|=> prdata[STS_RX] == $past(rx_irq_pending) && prdata[STS_PRT] == $past(protection_tx_irq_pending))
		else $error("pending flags misreported");
	a_reserved_zero: assert property (
		setup_ph && !pwrite && aligned && (idx == IDX_TIMING0 || idx == IDX_TIMING1)
		|=> prdata[31:8] == 24'h000000 && (prdata[7] == 1'b0) && (($past(idx) != IDX_TIMING1) || prdata[6:2] == 5'h00))
		else $error("reserved bits read non-zero");

	c_addr_ack:   cover property (state_q == S_ADDR ##1 state_q == S_AACK);
	c_read_byte:  cover property (state_q == S_AACK ##1 state_q == S_RDATA);
	c_wr_reject:  cover property (wr_reject_q);
	c_irq_raised: cover property ($fell(interrupt_out_n));
endmodule
`default_nettype wire

// >>> ddc_source_model.sv
/* Video source on the DDC pins: start, an address byte, optionally one write data byte,
   the ack after each, then stop.
   Assumes an open-drain data line with a pull-up and a slow clock of 400 pclk per half bit. */
`timescale 1ns/1ns
`default_nettype none
module ddc_source_model (
	// Clock
	input  wire logic pclk,
	// Device side of the data line
	input  wire logic dev_oe_n,
	input  wire logic dev_data,
	// Bus lines
	output var  logic scl,
	output wire logic sda
);
	logic drv = 1'b1;
	// Pull-up: low when either party pulls
	assign sda = drv & (dev_oe_n | dev_data);
	initial scl = 1'b1;
	task automatic half();
		repeat (200) @(posedge pclk);
	endtask
	// Clock low is far above delay plus filter
	task automatic byte9(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= -1; i--) begin
			scl <= 1'b0;
			half();
			drv <= (i < 0) ? 1'b1 : b[i[2:0]];
			half();
			scl <= 1'b1;
			half();
			ack = !sda;
			half();
		end
	endtask
	task automatic stop_cond();
		scl <= 1'b0;
		drv <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		drv <= 1'b1;
		half();
	endtask
	task automatic addr_byte(input logic [7:0] b, output logic ack);
		drv <= 1'b0;
		half();
		byte9(b, ack);
		stop_cond();
	endtask
	// Data byte only after the address was taken
	task automatic write_frame(input logic [7:0] b, input logic [7:0] d, output logic ack);
		drv <= 1'b0;
		half();
		byte9(b, ack);
		if (ack) begin
			byte9(d, ack);
		end
		stop_cond();
	endtask
endmodule
`default_nettype wire

// >>> bridge_ddc_display_config_bench.sv
/* Self-checking bench: APB register tests, control outputs, interrupts, DDC address handling.
   Assumes the DDC source model and a 250 MHz pclk. */
`timescale 1ns/1ns
`default_nettype none
module bridge_ddc_display_config_bench;
	import bridge_cfg_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, r;
	logic [31:0] prdata;
	logic        pready, pslverr, oe_n, dout, irq_n, e, a, scl;
	logic        rx_irq = 1'b0, prt_irq = 1'b0, strap_b = 1'b0, xs, rn, xrd, wv;
	logic [7:0]  v, wd, idd = 8'h80;
	wire logic   sda;
	wire logic [6:0] ctl;
	int          num_errors = 0, checks = 0, cyc = 0, xs_cnt = 0, rn_cnt = 0, wv_cnt = 0;
	bridge_ddc_display_config DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
		.prdata, .pready, .pslverr, .display_channel_clock(scl), .display_channel_data_in(sda),
		.display_channel_data_out(dout), .display_channel_data_oe_n(oe_n), .id_rd_data(idd), .id_rd_next(rn),
		.id_xfer_start(xs), .id_xfer_read(xrd), .id_wr_valid(wv), .id_wr_data(wd), .strap_pin_a(1'b1),
		.strap_pin_b(strap_b),
		.rx_irq_pending(rx_irq), .protection_tx_irq_pending(prt_irq), .interrupt_out_n(irq_n),
		.external_control_select(ctl[6]), .receiver_auto_init_en(ctl[5]), .protection_auto_setup_en(ctl[4]),
		.remote_id_load_en(ctl[3]), .audio_tdm_en(ctl[2]), .audio_local_sel(ctl[1]), .aux_audio_en(ctl[0]));
	ddc_source_model host (.pclk, .dev_oe_n(oe_n), .dev_data(dout), .scl, .sda);
	initial forever #2 pclk = ~pclk;
	// Tests need about 40000 cycles; also counts memory port pulses
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (xs) xs_cnt <= xs_cnt + 1;
		if (rn) rn_cnt <= rn_cnt + 1;
		if (wv) wv_cnt <= wv_cnt + 1;
		if (cyc == 60000) begin
			num_errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
		apb(1'b0, ad, 32'h0);
		chk(r, exp);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		rd(12'h144, 32'ha0);
		rd(12'h148, 32'h1e);
		rd(12'h14c, 32'h00);
		rd(12'h150, 32'h01);
		apb(1'b1, 12'h148, 32'hff);
		rd(12'h148, 32'h7f);
		apb(1'b1, 12'h14c, 32'hff);
		rd(12'h14c, 32'h03);
		rd(12'h200, 32'h00);
		chk(e, 1'b1);
		$display("register test done");
		// Single bits, then all clear
		for (int b = 0; b < 9; b++) begin
			v = 8'h01 << b;
			apb(1'b1, 12'h150, {24'h0, v});
			repeat (2) @(posedge pclk);
			chk(ctl, {v[7], ~(v[4] | v[7]), ~(v[3] | v[7]), ~v[5], v[2:0]});
		end
		$display("control test done");
		apb(1'b1, 12'h15c, 32'h07);
		rx_irq <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(irq_n, 1'b1);
		rd(12'h140, 32'h40);
		rd(12'h158, 32'h01);
		rx_irq <= 1'b0;
		prt_irq <= 1'b1;
		apb(1'b1, 12'h150, 32'h40);
		rd(12'h140, 32'h20);
		rd(12'h158, 32'h02);
		repeat (2) @(posedge pclk);
		chk(irq_n, 1'b1);
		rx_irq <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(irq_n, 1'b0);
		rd(12'h158, 32'h01);
		repeat (2) @(posedge pclk);
		chk(irq_n, 1'b1);
		$display("interrupt test done");
		host.write_frame(8'ha0, 8'h5a, a);
		chk(a, 1'b1);
		chk(wd, 8'h5a);
		chk(xrd, 1'b0);
		host.addr_byte(8'hb0, a);
		chk(a, 1'b0);
		apb(1'b1, 12'h144, 32'ha1);
		host.addr_byte(8'ha0, a);
		chk(a, 1'b0);
		rd(12'h158, 32'h04);
		host.addr_byte(8'ha1, a);
		chk(a, 1'b1);
		chk(xrd, 1'b1);
		chk(xs_cnt, 32'h2);
		chk(rn_cnt, 32'h1);
		chk(wv_cnt, 32'h1);
		$display("ddc test done");
		// Second reset with the other strap level
		strap_b <= 1'b1;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		rd(12'h150, 32'ha1);
		chk(ctl, 7'h41);
		$display("strap test done");
		final_report();
	end
endmodule
`default_nettype wire
